/* design/mpt_regs.vh */
// Purpose: register map, field positions and reset values of the time base
// Assumes: 32-bit AXI4-Lite words, 16-bit registers in the low half
// Notes:   byte offsets are word aligned
`ifndef MPT_REGS_VH
`define MPT_REGS_VH

`define MPT_OFS_TCON      5'h00
`define MPT_OFS_TMR       5'h04
`define MPT_OFS_TPER      5'h08
`define MPT_OFS_SECMP     5'h0C
`define MPT_OFS_CON1      5'h10
`define MPT_OFS_KEY       5'h14
`define MPT_OFS_FLTA      5'h18
`define MPT_OFS_FLTB      5'h1C

`define MPT_TCON_MASK     16'hA0FF
`define MPT_CON1_MASK     16'h0777
`define MPT_FLT_MASK      16'h3F87
`define MPT_FLT_RESET     16'h0007
`define MPT_CON1_PEN_ALL  16'h0077

`define MPT_KEY_FIRST     16'hABCD
`define MPT_KEY_SECOND    16'h4321

`define MPT_BIT_RUN       15
`define MPT_BIT_IDLE      13
`define MPT_OPS_HI        7
`define MPT_OPS_LO        4
`define MPT_CKPS_HI       3
`define MPT_CKPS_LO       2
`define MPT_MODE_HI       1
`define MPT_MODE_LO       0
`define MPT_BIT_DIR       15

`define MPT_MODE_FREE     2'h0
`define MPT_MODE_SINGLE   2'h1
`define MPT_MODE_UPDN     2'h2
`define MPT_MODE_UPDN2    2'h3

`define MPT_RESP_OKAY     2'h0
`define MPT_RESP_SLVERR   2'h2

`endif

/* design/mpt_prescale.v */
// Purpose: input clock prescaler producing a count tick every 1/4/16/64 cycles
// Assumes: enable low holds the divider cleared
// Notes:   divider restarts whenever the time base is halted
`timescale 1ns/1ns
module mpt_prescale #(
	parameter W = 6
) (
	// clock and reset
	input  wire         aclk,
	input  wire         aresetn,
	// control
	input  wire         enable,
	input  wire [1:0]   code,
	// tick
	output reg          tick
);
	reg  [W-1:0] div_reg;
	reg  [W-1:0] limit;

	always @* begin
		case (code)
			2'h0: limit = 6'h00;
			2'h1: limit = 6'h03;
			2'h2: limit = 6'h0F;
			default: limit = 6'h3F;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			div_reg <= {W{1'b0}};
			tick    <= 1'b0;
		end else if (!enable) begin
			div_reg <= {W{1'b0}};
			tick    <= 1'b0;
		end else if (div_reg >= limit) begin
			div_reg <= {W{1'b0}};
			tick    <= 1'b1;
		end else begin
			div_reg <= div_reg + 1'b1;
			tick    <= 1'b0;
		end
	end
endmodule

/* design/mpt_timebase.v */
// What this block does
// - counter runs only while the run bit is set.
// - idle-halt set stops counting in processor idle; clear keeps counting.
// - output events divided by postscale code plus one, 1:1 to 1:16.
// - prescale codes 00..11 give count period of 1, 4, 16, 64 cycles.
// - mode 00 free, 01 single pulse, 10 up/down, 11 up/down double update.
// - counter register top bit is read-only direction, one when counting down.
// - low fifteen bits of counter register hold count, software read/write.
// - period is fifteen bits; its top register bit is unimplemented.
// - special trigger fires when compare value equals count.
// - special trigger also needs direction bit equal to count direction.
// - per pair, mode bit set independent, clear complementary.
// - high-side enable set gives pin to PWM, clear to general I/O.
// - low-side enable set gives pin to PWM, clear to general I/O.
// - pair control register writes only take effect after unlock.
// - pin enable reset value follows the pins-to-port configuration bit.
// - unimplemented bits ignore writes and read as zero.
// - unlock is 0xABCD then 0x4321 to key, protected write next.
// - complementary mode drives low-side as complement of high-side.
// - any reset enables both faults in latched mode.
//
// Purpose: motor PWM time base, special event trigger and pin control
// Assumes: AXI4-Lite slave, one write and one read outstanding at a time
// Notes:   duty generators are outside; they feed duty_high_in per pair
`timescale 1ns/1ns
`include "mpt_regs.vh"
module mpt_timebase #(
	parameter CW = 15,
	parameter NP = 3
) (
	// clock and reset
	input  wire          aclk,
	input  wire          aresetn,
	// configuration and core state
	input  wire          pins_to_port_at_reset,
	input  wire          cpu_idle,
	// duty generator inputs, one per pair
	input  wire [NP-1:0] duty_high_in,
	// AXI4-Lite write address
	input  wire [4:0]    s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output reg           s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output reg           s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]    s_axi_bresp,
	output reg           s_axi_bvalid,
	input  wire          s_axi_bready,
	// AXI4-Lite read
	input  wire [4:0]    s_axi_araddr,
	input  wire          s_axi_arvalid,
	output reg           s_axi_arready,
	output reg  [31:0]   s_axi_rdata,
	output reg  [1:0]    s_axi_rresp,
	output reg           s_axi_rvalid,
	input  wire          s_axi_rready,
	// time base status
	output reg  [CW-1:0] count_out,
	output reg           count_dir_flag,
	output reg           special_event,
	output reg           postscale_event,
	// pins
	output reg  [NP-1:0] pwm_high,
	output reg  [NP-1:0] pwm_low,
	output reg  [NP-1:0] high_output_en,
	output reg  [NP-1:0] low_output_en,
	output reg  [NP-1:0] pair_independent_sel,
	output reg  [15:0]   fault_a_control,
	output reg  [15:0]   fault_b_control
);
	reg  [15:0]   tcon_reg;
	reg  [CW-1:0] count_reg;
	reg  [CW-1:0] period_reg;
	reg  [CW-1:0] trig_cmp_reg;
	reg           trig_dir_reg;
	reg  [1:0]    key_state_reg;
	reg  [3:0]    post_cnt_reg;
	reg  [4:0]    wr_addr_reg;
	reg  [31:0]   wr_data_reg;
	reg  [3:0]    wr_strb_reg;
	reg           have_aw_reg;
	reg           have_w_reg;
	reg           rst_seen_reg;
	reg  [CW-1:0] count_next;
	reg           dir_next;
	reg           wrap_evt;
	reg           stop_pulse;

	wire       run        = tcon_reg[`MPT_BIT_RUN];
	wire       idle_halt  = tcon_reg[`MPT_BIT_IDLE];
	wire [3:0] post_code  = tcon_reg[`MPT_OPS_HI:`MPT_OPS_LO];
	wire [1:0] ckps       = tcon_reg[`MPT_CKPS_HI:`MPT_CKPS_LO];
	wire [1:0] count_mode_sel = tcon_reg[`MPT_MODE_HI:`MPT_MODE_LO];
	wire       counting   = run && !(idle_halt && cpu_idle);
	wire       tick;
	// a tick already in flight when the run bit drops must not move the count
	wire       step       = tick && counting;
	wire       do_write   = have_aw_reg && have_w_reg && !s_axi_bvalid;
	wire       lo_lanes   = wr_strb_reg[0] && wr_strb_reg[1];
	wire [15:0] wval      = wr_data_reg[15:0];
	wire       unlocked   = (key_state_reg == 2'h2);
	wire [CW-1:0] zero_cnt = {CW{1'b0}};

	mpt_prescale #(
		.W (6)
	) u_prescale (
		.aclk    (aclk),
		.aresetn (aresetn),
		.enable  (counting),
		.code    (ckps),
		.tick    (tick)
	);

	// count sequencing per mode
	always @* begin
		count_next = count_reg;
		dir_next   = count_dir_flag;
		wrap_evt   = 1'b0;
		stop_pulse = 1'b0;
		if (step) begin
			case (count_mode_sel)
				`MPT_MODE_FREE: begin
					dir_next = 1'b0;
					if (count_reg >= period_reg) begin
						count_next = zero_cnt;
						wrap_evt   = 1'b1;
					end else begin
						count_next = count_reg + 1'b1;
					end
				end
				`MPT_MODE_SINGLE: begin
					dir_next = 1'b0;
					if (count_reg >= period_reg) begin
						count_next = zero_cnt;
						wrap_evt   = 1'b1;
						stop_pulse = 1'b1;
					end else begin
						count_next = count_reg + 1'b1;
					end
				end
				default: begin
					if (!count_dir_flag) begin
						if (count_reg >= period_reg) begin
							dir_next   = 1'b1;
							count_next = count_reg - 1'b1;
							wrap_evt   = (count_mode_sel == `MPT_MODE_UPDN2);
						end else begin
							count_next = count_reg + 1'b1;
						end
					end else begin
						if (count_reg == zero_cnt) begin
							dir_next   = 1'b0;
							count_next = count_reg + 1'b1;
							wrap_evt   = 1'b1;
						end else begin
							count_next = count_reg - 1'b1;
						end
					end
				end
			endcase
		end
	end

	// write channel capture, both orders accepted
	always @(posedge aclk) begin
		if (!aresetn) begin
			have_aw_reg   <= 1'b0;
			have_w_reg    <= 1'b0;
			wr_addr_reg   <= 5'h00;
			wr_data_reg   <= 32'h00000000;
			wr_strb_reg   <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `MPT_RESP_OKAY;
		end else begin
			s_axi_awready <= !have_aw_reg && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !have_w_reg && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				have_aw_reg <= 1'b1;
				wr_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				have_w_reg  <= 1'b1;
				wr_data_reg <= s_axi_wdata;
				wr_strb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				have_aw_reg  <= 1'b0;
				have_w_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_addr_reg > `MPT_OFS_FLTB ||
					wr_addr_reg[1:0] != 2'h0) ?
					`MPT_RESP_SLVERR : `MPT_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register file and time base state
	always @(posedge aclk) begin
		if (!aresetn) begin
			tcon_reg             <= 16'h0000;
			count_reg            <= zero_cnt;
			count_dir_flag       <= 1'b0;
			period_reg           <= zero_cnt;
			trig_cmp_reg         <= zero_cnt;
			trig_dir_reg         <= 1'b0;
			key_state_reg        <= 2'h0;
			pair_independent_sel <= {NP{1'b0}};
			high_output_en       <= {NP{1'b0}};
			low_output_en        <= {NP{1'b0}};
			fault_a_control      <= `MPT_FLT_RESET;
			fault_b_control      <= `MPT_FLT_RESET;
			rst_seen_reg         <= 1'b0;
		end else begin
			count_reg      <= count_next;
			count_dir_flag <= dir_next;
			if (stop_pulse)
				tcon_reg[`MPT_BIT_RUN] <= 1'b0;
			rst_seen_reg <= 1'b1;
			// strap caught once after release
			if (!rst_seen_reg) begin
				high_output_en <= {NP{!pins_to_port_at_reset}};
				low_output_en  <= {NP{!pins_to_port_at_reset}};
			end
			// any access other than key writes breaks the unlock chain
			if (s_axi_arvalid && s_axi_arready)
				key_state_reg <= 2'h0;
			if (do_write) begin
				if (wr_addr_reg != `MPT_OFS_KEY)
					key_state_reg <= 2'h0;
				if (lo_lanes) begin
					case (wr_addr_reg)
						`MPT_OFS_TCON:
							tcon_reg <= wval & `MPT_TCON_MASK;
						`MPT_OFS_TMR:
							count_reg <= wval[CW-1:0];
						`MPT_OFS_TPER:
							period_reg <= wval[CW-1:0];
						`MPT_OFS_SECMP: begin
							trig_cmp_reg <= wval[CW-1:0];
							trig_dir_reg <= wval[15];
						end
						`MPT_OFS_KEY: begin
							if (key_state_reg == 2'h0 && wval == `MPT_KEY_FIRST)
								key_state_reg <= 2'h1;
							else if (key_state_reg == 2'h1 &&
								wval == `MPT_KEY_SECOND)
								key_state_reg <= 2'h2;
							else
								key_state_reg <= 2'h0;
						end
						`MPT_OFS_CON1: begin
							if (unlocked) begin
								pair_independent_sel <= wval[10:8];
								high_output_en <= wval[6:4];
								low_output_en  <= wval[2:0];
							end
						end
						`MPT_OFS_FLTA: begin
							if (unlocked)
								fault_a_control <= wval & `MPT_FLT_MASK;
						end
						`MPT_OFS_FLTB: begin
							if (unlocked)
								fault_b_control <= wval & `MPT_FLT_MASK;
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	// events and pins
	always @(posedge aclk) begin
		if (!aresetn) begin
			post_cnt_reg    <= 4'h0;
			postscale_event <= 1'b0;
			special_event   <= 1'b0;
			count_out       <= zero_cnt;
			pwm_high        <= {NP{1'b0}};
			pwm_low         <= {NP{1'b0}};
		end else begin
			count_out     <= count_reg;
			special_event <= step && (count_reg == trig_cmp_reg) &&
				(trig_dir_reg == count_dir_flag);
			postscale_event <= 1'b0;
			if (wrap_evt) begin
				if (post_cnt_reg >= post_code) begin
					post_cnt_reg    <= 4'h0;
					postscale_event <= 1'b1;
				end else begin
					post_cnt_reg <= post_cnt_reg + 1'b1;
				end
			end
			pwm_high <= duty_high_in & high_output_en;
			// complementary pairs get the inverse of the high side
			pwm_low <= (pair_independent_sel & duty_high_in |
				~pair_independent_sel & ~duty_high_in) & low_output_en;
		end
	end

	// read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `MPT_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `MPT_RESP_OKAY;
				case (s_axi_araddr)
					`MPT_OFS_TCON:  s_axi_rdata <= {16'h0000, tcon_reg};
					`MPT_OFS_TMR:   s_axi_rdata <= {16'h0000,
						count_dir_flag, count_reg};
					`MPT_OFS_TPER:  s_axi_rdata <= {17'h00000, period_reg};
					`MPT_OFS_SECMP: s_axi_rdata <= {16'h0000,
						trig_dir_reg, trig_cmp_reg};
					`MPT_OFS_CON1:  s_axi_rdata <= {21'h000000,
						pair_independent_sel, 1'b0, high_output_en,
						1'b0, low_output_en};
					`MPT_OFS_KEY:   s_axi_rdata <= 32'h00000000;
					`MPT_OFS_FLTA:  s_axi_rdata <= {16'h0000, fault_a_control};
					`MPT_OFS_FLTB:  s_axi_rdata <= {16'h0000, fault_b_control};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `MPT_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

/* sim/mpt_gate_model.sv */
// Purpose: gate driver stage seen from the six pwm pins
// Assumes: a pin released by the unit leaves its gate off
// Notes:   only complementary pairs are judged; independent pairs may overlap
`timescale 1ns/1ns
module mpt_gate_model #(
	parameter NP = 3
) (
	// clock and reset
	input  wire          aclk,
	input  wire          aresetn,
	// pins from the unit
	input  wire [NP-1:0] pwm_high,
	input  wire [NP-1:0] pwm_low,
	input  wire [NP-1:0] high_output_en,
	input  wire [NP-1:0] low_output_en,
	input  wire [NP-1:0] pair_independent_sel,
	// cycles with both gates of a complementary pair on
	output logic [7:0]   shoot_cnt
);
	wire [NP-1:0] both = pwm_high & pwm_low & high_output_en & low_output_en;

	always @(posedge aclk) begin
		if (!aresetn)
			shoot_cnt <= 8'h00;
		else if (|(both & ~pair_independent_sel))
			shoot_cnt <= shoot_cnt + 8'h01;
	end
endmodule

/* sim/mpt_timebase_asserts.sv */
// Purpose: port-level checks of the time base pins and register bus
// Assumes: one clock, synchronous active-low reset
// Notes:   pin checks allow one cycle of lag after an enable change
`timescale 1ns/1ns
`include "mpt_regs.vh"
module mpt_chk #(
	parameter NP = 3
) (
	// clock, reset, strap
	input wire          aclk,
	input wire          aresetn,
	input wire          pins_to_port_at_reset,
	// register bus
	input wire          s_axi_awvalid,
	input wire          s_axi_awready,
	input wire          s_axi_wvalid,
	input wire          s_axi_wready,
	input wire          s_axi_bvalid,
	input wire          s_axi_arvalid,
	input wire          s_axi_arready,
	input wire          s_axi_rvalid,
	input wire [31:0]   s_axi_rdata,
	input wire [1:0]    s_axi_rresp,
	// pins and protected registers
	input wire [NP-1:0] pwm_high,
	input wire [NP-1:0] pwm_low,
	input wire [NP-1:0] high_output_en,
	input wire [NP-1:0] low_output_en,
	input wire [NP-1:0] pair_independent_sel,
	input wire [15:0]   fault_a_control,
	input wire [15:0]   fault_b_control
);
	wire [NP-1:0] m = ~pair_independent_sel & high_output_en & low_output_en;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_hen;
		(pwm_high & ~high_output_en & ~$past(high_output_en)) == 0;
	endproperty
	a_hen: assert property (p_hen) else $error("high pin live");
	property p_len;
		(pwm_low & ~low_output_en & ~$past(low_output_en)) == 0;
	endproperty
	a_len: assert property (p_len) else $error("low pin live");
	// settle two cycles so a mode change is not judged mid-update
	property p_comp;
		m == $past(m) && m == $past(m, 2) |-> (m & ~(pwm_high ^ pwm_low)) == 0;
	endproperty
	a_comp: assert property (p_comp) else $error("pair not inverse");
	property p_flt;
		!$past(aresetn) |-> fault_a_control == `MPT_FLT_RESET
			&& fault_b_control == `MPT_FLT_RESET;
	endproperty
	a_flt: assert property (p_flt) else $error("fault reset value");
	property p_strap;
		$rose(aresetn) |-> ##[1:2] {high_output_en, low_output_en}
			== {(2 * NP){!pins_to_port_at_reset}};
	endproperty
	a_strap: assert property (p_strap) else $error("enable reset");
	property p_rd;
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000
			&& (s_axi_rresp == `MPT_RESP_OKAY || s_axi_rdata == 32'h0);
	endproperty
	a_rd: assert property (p_rd) else $error("read data high bits");
	property p_bresp;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##[1:3] s_axi_bvalid;
	endproperty
	a_bresp: assert property (p_bresp) else $error("late write response");
	property p_rresp;
		s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
	endproperty
	a_rresp: assert property (p_rresp) else $error("late read data");
endmodule

bind mpt_timebase mpt_chk #(.NP(NP)) i_mpt_chk (.*);

/* sim/testbench.sv */
// Purpose: self-checking bench for the motor pwm time base
// Assumes: strap high at first, low for the mid-run reset
// Notes:   timing is judged from event gaps, not from pipeline depth
`timescale 1ns/1ns
`include "mpt_regs.vh"
module testbench;
	logic        aclk, aresetn, pins_to_port_at_reset, cpu_idle;
	logic [2:0]  duty_high_in;
	logic [4:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire         s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire  [14:0] count_out;
	wire         count_dir_flag, special_event, postscale_event;
	wire  [2:0]  pwm_high, pwm_low, high_output_en, low_output_en;
	wire  [2:0]  pair_independent_sel;
	wire  [15:0] fault_a_control, fault_b_control;
	wire  [7:0]  shoot_cnt;
	int          err_total, comparisons, g, mx, n;
	logic [15:0] d, q;
	logic [1:0]  rr;
	logic        dir, sel;
	wire         ev = sel ? special_event : postscale_event;

	mpt_timebase i_mpt_timebase (.*);
	mpt_gate_model i_mpt_gate_model (.*);

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	always @(posedge aclk) duty_high_in <= 3'($urandom);

	task test_done;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
		comparisons++;
		if (v !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, e, v);
		end
	endtask
	task wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [4:0] a, output logic [15:0] v);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata[15:0];
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task rc(input string nm, input logic [4:0] a, input logic [15:0] e);
		rd(a, q);
		chk(nm, e, q);
	endtask
	task ul;
		wr(`MPT_OFS_KEY, `MPT_KEY_FIRST);
		wr(`MPT_OFS_KEY, `MPT_KEY_SECOND);
	endtask
	// stop and clear first so the count never starts above a new period
	task cfg(input logic [15:0] per, input logic [15:0] cmp, input logic [15:0] tc);
		wr(`MPT_OFS_TCON, 16'h0000);
		wr(`MPT_OFS_TMR, 16'h0000);
		wr(`MPT_OFS_TPER, per);
		wr(`MPT_OFS_SECMP, cmp);
		wr(`MPT_OFS_TCON, tc);
	endtask
	// skip the partial gap and one full gap after a reconfiguration, then measure one
	task gap(input logic s);
		sel = s;
		mx = 0;
		repeat (2) begin
			n = 0;
			do begin
				@(posedge aclk);
				n++;
			end while (ev !== 1'b1 && n < 3000);
		end
		g = 0;
		do begin
			@(posedge aclk);
			g++;
			if (count_out > mx) mx = count_out;
			dir = count_dir_flag;
		end while (ev !== 1'b1 && g < 3000);
	endtask
	function logic [15:0] keep(input logic [4:0] a, input logic [15:0] v);
		if (a == `MPT_OFS_TCON)
			return v & `MPT_TCON_MASK;
		if (a == `MPT_OFS_SECMP)
			return v;
		// direction flag and unimplemented period bit read zero
		return v & 16'h7FFF;
	endfunction

	initial begin
		#2000000;
		err_total++;
		$display("BAD watchdog exp done got timeout");
		test_done;
	end

	initial begin
		{aresetn, cpu_idle, s_axi_awaddr, s_axi_araddr} = 0;
		{s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
		{s_axi_arvalid, s_axi_rready, err_total, comparisons} = 0;
		pins_to_port_at_reset = 1'b1;
		s_axi_wstrb = 4'hF;
		d = 16'($urandom(35656));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 8; i++)
			rc("reset", 5'(i * 4), i > 5 ? `MPT_FLT_RESET : 16'h0000);
		rd(5'h02, q);
		chk("misaligned", `MPT_RESP_SLVERR, rr);
		repeat (4) for (int i = 0; i < 4; i++) begin
			// run bit kept clear so the count holds still while read back
			d = 16'($urandom) & (i == 0 ? 16'h7FFF : 16'hFFFF);
			wr(5'(i * 4), d);
			rc("reg", 5'(i * 4), keep(5'(i * 4), d));
		end
		wr(`MPT_OFS_TPER, 16'h0123);
		chk("write resp", `MPT_RESP_OKAY, rr);
		s_axi_wstrb <= 4'hE;
		wr(`MPT_OFS_TPER, 16'h0456);
		s_axi_wstrb <= 4'hF;
		rc("strobe", `MPT_OFS_TPER, 16'h0123);
		wr(5'h03, 16'h0000);
		chk("bad write", `MPT_RESP_SLVERR, rr);
		wr(`MPT_OFS_CON1, `MPT_CON1_MASK);
		rc("locked", `MPT_OFS_CON1, 16'h0000);
		ul;
		wr(`MPT_OFS_CON1, `MPT_CON1_PEN_ALL);
		rc("unlocked", `MPT_OFS_CON1, `MPT_CON1_PEN_ALL);
		chk("enables", 6'h3F, {high_output_en, low_output_en});
		ul;
		rd(`MPT_OFS_TPER, q);
		wr(`MPT_OFS_CON1, 16'h0000);
		rc("broken", `MPT_OFS_CON1, `MPT_CON1_PEN_ALL);
		// fault pins are outside this block; taken as held high here
		ul;
		wr(`MPT_OFS_FLTA, 16'h0000);
		ul;
		wr(`MPT_OFS_FLTB, 16'h0000);
		chk("faults", 32'h0, {fault_a_control, fault_b_control});
		chk("shoot", 8'h00, shoot_cnt);
		ul;
		wr(`MPT_OFS_CON1, `MPT_CON1_MASK);
		chk("indep", 3'h7, pair_independent_sel);
		for (int c = 0; c < 4; c++) begin
			cfg(16'h0001, 16'h0000, 16'h8000 | 16'(c << 2));
			gap(1'b0);
			chk("prescale", 2 << (2 * c), g);
			chk("top", 1, mx);
		end
		for (int k = 0; k < 16; k++) begin
			cfg(16'h0003, 16'h0000, 16'h8000 | 16'(k << 4));
			gap(1'b0);
			chk("postscale", 4 * (k + 1), g);
		end
		cfg(16'h0005, 16'h0000, 16'h8002);
		gap(1'b0);
		chk("updown", 10, g);
		chk("updown top", 5, mx);
		cfg(16'h0005, 16'h0000, 16'h8003);
		gap(1'b0);
		chk("double", 5, g);
		cfg(16'h0007, 16'h0003, 16'h8000);
		gap(1'b1);
		chk("trigger", 8, g);
		cfg(16'h0008, 16'h8004, 16'h8002);
		gap(1'b1);
		chk("trigger down", 16, g);
		chk("dir", 1, dir);
		cfg(16'h0007, 16'h8003, 16'h8000);
		n = 0;
		repeat (40) begin
			@(posedge aclk);
			if (special_event !== 1'b0) n++;
		end
		chk("no trigger", 0, n);
		cfg(16'h0004, 16'h0000, 16'h8001);
		repeat (20) @(posedge aclk);
		rc("single", `MPT_OFS_TCON, 16'h0001);
		q = {1'b0, count_out};
		repeat (8) @(posedge aclk);
		chk("stopped", q, count_out);
		cpu_idle <= 1'b1;
		cfg(16'h0064, 16'h0000, 16'hA000);
		q = {1'b0, count_out};
		repeat (8) @(posedge aclk);
		chk("idle halt", q, count_out);
		wr(`MPT_OFS_TCON, 16'h8000);
		repeat (8) @(posedge aclk);
		chk("idle run", 1, count_out != q[14:0]);
		// second reset with the strap low: pins come up owned by the unit
		aresetn <= 1'b0;
		pins_to_port_at_reset <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("strap", 6'h3F, {high_output_en, low_output_en});
		chk("pairs", 3'h0, pair_independent_sel);
		cfg(16'h0008, 16'h0000, 16'h800E);
		n = 0;
		while (count_dir_flag !== 1'b1 && n < 2000) begin
			@(posedge aclk);
			n++;
		end
		// reversal at period 8 leaves count 7 for a full 64-cycle tick
		rc("dir bit", `MPT_OFS_TMR, 16'h8007);
		chk("shoot end", 8'h00, shoot_cnt);
		test_done;
	end
endmodule
